// >>> rtl/asd_seq_dma.sv
/*
  Sequencer input unit, sample FIFO and bus-master transfer engine.
  Assumes synchronous inputs, a host port answering each write with
  ack or abort, and converters raising convDone on valid results.
*/
// Strobed register access is this design's own decision.
// Notes on behaviour
// - Three-bit termination reason, cleared on new buffer, set on termination.
// - Input unit error before count reached terminates buffer as abort.
// - Count reached, or next trigger in continuous frame mode, ends block.
// - Exhausted buffer terminates as buffer end; new buffer needed.
// - Bus abort sets transfer error, halts engine; cleared on disable.
// - Busy flag high while engine moves data.
// - Idle flag, cleared on disable; length write accepted only when idle.
// - Early frame trigger outside continuous sets frame error, halts unit.
// - Conversion clock during running conversion sets rate error, halts.
// - Storing into full FIFO sets overflow error, halts unit.
// - Active flag set on start or trigger, cleared when count finishes.
// - Input unit idle flag, cleared while unit disabled.
// - 28-bit event count per request or trigger; zero means continuous.
// - Channels converted ascending from zero, converters in parallel.
// - Each clock event expands into one pulse per active channel.
// - Wrapping 28-bit event counter, cleared on start or frame trigger.
// - FIFO fill level reported in bytes, 64 KB, two bytes per sample.
// - Base address captured when the length register is written.
// - Nonzero length write starts a transfer only while idle.
// - Next write address readable by software.
// - Status word written to status address on termination if enabled.
// - Status word little endian: reasons in 30:28, bytes in 27:0.
// - Control bit enables the status word write.
// - Self-clearing start bit launches a normal mode run.
// - Disable resets engine after finishing a transfer in progress.
// - Frame mode starts at the conversion clock falling edge after trigger.
`timescale 1ns/1ps
`default_nettype none
module asd_seq_dma #(
  parameter int NUM_ADC    = 4,
  parameter int CH_W       = 4,
  parameter int FIFO_DEPTH = asd_pkg::FIFO_BYTES / asd_pkg::SAMPLE_BYTES,
  parameter int AW         = 15
) (
  // Clock, reset and enable.
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  input  wire logic                    clkEn,
  // Register port.
  input  wire logic [11:0]             regAddr,
  input  wire logic [31:0]             regWrData,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  output logic      [31:0]             regRdData,
  // Converter side.
  input  wire logic                    convClk,
  input  wire logic                    frameTrig,
  input  wire logic [NUM_ADC*CH_W-1:0] chanCount,
  input  wire logic                    convDone,
  input  wire logic [NUM_ADC*16-1:0]   sampleData,
  output logic      [NUM_ADC-1:0]      convPulse,
  // Host memory write port.
  output logic                         memValid,
  output asd_pkg::asd_mem_req_type     memReq,
  input  wire logic                    memAck,
  input  wire logic                    memMasterAbort,
  input  wire logic                    memTargetAbort
);
  typedef enum {IU_OFF, IU_IDLE, IU_WAIT, IU_PULSE, IU_CONV, IU_STORE, IU_COUNT,
                IU_HALT} asd_iu_type;
  typedef enum {D_OFF, D_IDLE, D_XFER, D_WRITE, D_STAT, D_STATW, D_ERR} asd_dma_type;

  asd_iu_type               iuState_r;
  asd_dma_type              dmaState_r;
  logic                     iuEna_r, frameMode_r, dmaEna_r, statEna_r, startReq_r;
  logic [asd_pkg::CNT_W-1:0] target_r, len_r, evCnt_r, remain_r, bytes_r;
  logic [31:0]              base_r, stAddr_r, writePtr_r;
  logic                     active_r, frameErr_r, cnvErr_r, ovfErr_r, frameFirst_r;
  logic                     convClkD_r, xferErr_r;
  logic [2:0]               term_r;
  logic [CH_W-1:0]          ch_r, maxCh;
  logic [$clog2(NUM_ADC)-1:0] adc_r, lastLane;
  logic [NUM_ADC-1:0]       laneOn;
  asd_pkg::asd_sample_type  mem [FIFO_DEPTH];
  asd_pkg::asd_sample_type  head, curSample_r;
  logic [AW-1:0]            wrPtr_r, rdPtr_r;
  logic [AW:0]              fill_r;
  logic                     push, pop, fifoFull, fifoEmpty, convFall, trigHit;
  logic                     continuous, lenStart, iuErr, lastPush;
  asd_pkg::asd_sample_type  pushEntry;
  localparam logic [asd_pkg::CNT_W-1:0] STEP = asd_pkg::CNT_W'(asd_pkg::SAMPLE_BYTES);

  // Falling edge of the conversion clock is the conversion event.
  assign convFall   = convClkD_r & ~convClk;
  assign continuous = (target_r == '0);
  assign iuErr      = frameErr_r | cnvErr_r | ovfErr_r;
  assign fifoFull   = (fill_r == (AW+1)'(FIFO_DEPTH));
  assign fifoEmpty  = (fill_r == '0);
  assign head       = mem[rdPtr_r];
  // Frame trigger is only meaningful while the unit runs in frame mode.
  assign trigHit    = frameTrig & frameMode_r & iuEna_r;
  // A nonzero length written while idle opens a new buffer.
  assign lenStart   = regWr && (regAddr == asd_pkg::OFS_LEN) &&
                      (dmaState_r == D_IDLE) &&
                      (regWrData[asd_pkg::CNT_W-1:0] != '0);

  // Active lanes, the widest channel count and the last active lane.
  always_comb begin
    maxCh    = '0;
    lastLane = '0;
    for (int a = 0; a < NUM_ADC; a++) begin
      laneOn[a] = (chanCount[a*CH_W +: CH_W] > ch_r);
      if (chanCount[a*CH_W +: CH_W] > maxCh) begin
        maxCh = chanCount[a*CH_W +: CH_W];
      end
      if (laneOn[a]) begin
        lastLane = a[$clog2(NUM_ADC)-1:0];
      end
    end
  end

  // Store phase pushes one active lane per cycle into the FIFO.
  assign push     = (iuState_r == IU_STORE) && laneOn[adc_r] && !fifoFull;
  assign lastPush = (adc_r == lastLane) && (ch_r == maxCh - 1'b1) &&
                    (evCnt_r + 1'b1 == target_r);
  always_comb begin
    pushEntry.data       = sampleData[adc_r*16 +: 16];
    pushEntry.blockEnd   = lastPush;
    pushEntry.frameStart = frameFirst_r;
  end

  // Software writes to control and configuration registers.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      iuEna_r     <= 1'b0;
      frameMode_r <= 1'b0;
      dmaEna_r    <= 1'b0;
      statEna_r   <= 1'b0;
      startReq_r  <= 1'b0;
      target_r    <= '0;
      len_r       <= '0;
      base_r      <= asd_pkg::RST_WORD;
      stAddr_r    <= asd_pkg::RST_WORD;
    end else if (clkEn) begin
      startReq_r <= 1'b0;
      if (regWr) begin
        unique case (regAddr)
          asd_pkg::OFS_CTRL: begin
            iuEna_r     <= regWrData[asd_pkg::CTL_IU_ENA];
            frameMode_r <= regWrData[asd_pkg::CTL_FRAME];
            dmaEna_r    <= regWrData[asd_pkg::CTL_DMA_ENA];
            statEna_r   <= regWrData[asd_pkg::CTL_STAT_ENA];
            startReq_r  <= regWrData[asd_pkg::CTL_START];
          end
          asd_pkg::OFS_TARGET: target_r <= regWrData[asd_pkg::CNT_W-1:0];
          asd_pkg::OFS_LEN:    len_r    <= regWrData[asd_pkg::CNT_W-1:0];
          asd_pkg::OFS_BASE:   base_r   <= regWrData;
          asd_pkg::OFS_STADDR: stAddr_r <= regWrData;
          default: ;
        endcase
      end
    end
  end

  // Input unit sequencing: events, channel steps and result storage.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      iuState_r    <= IU_OFF;
      ch_r         <= '0;
      adc_r        <= '0;
      evCnt_r      <= '0;
      active_r     <= 1'b0;
      frameFirst_r <= 1'b0;
      convClkD_r   <= 1'b0;
      convPulse    <= '0;
    end else if (clkEn) begin
      convClkD_r <= convClk;
      convPulse  <= '0;
      if (push) begin
        frameFirst_r <= 1'b0;
      end
      if (!iuEna_r) begin
        iuState_r <= IU_OFF;
        active_r  <= 1'b0;
      end else if (iuErr || (iuState_r == IU_HALT)) begin
        iuState_r <= IU_HALT;
        active_r  <= 1'b0;
      end else begin
        // Frame trigger starts or restarts a frame.
        if (trigHit && (!active_r || continuous)) begin
          evCnt_r   <= '0;
          active_r  <= 1'b1;
          if (continuous && active_r) begin
            frameFirst_r <= 1'b1;
          end else begin
            iuState_r <= IU_WAIT;
          end
        end
        unique case (iuState_r)
          IU_OFF: iuState_r <= IU_IDLE;
          IU_IDLE: begin
            if (startReq_r && !frameMode_r) begin
              evCnt_r   <= '0;
              active_r  <= 1'b1;
              iuState_r <= IU_WAIT;
            end
          end
          IU_WAIT: begin
            if (convFall) begin
              ch_r      <= '0;
              iuState_r <= (maxCh == '0) ? IU_COUNT : IU_PULSE;
            end
          end
          IU_PULSE: begin
            convPulse <= laneOn;
            iuState_r <= IU_CONV;
          end
          IU_CONV: begin
            if (convDone) begin
              adc_r     <= '0;
              iuState_r <= IU_STORE;
            end
          end
          IU_STORE: begin
            if (adc_r == lastLane || !laneOn[adc_r]) begin
              if (adc_r >= lastLane) begin
                if (ch_r + 1'b1 < maxCh) begin
                  ch_r      <= ch_r + 1'b1;
                  iuState_r <= IU_PULSE;
                end else begin
                  iuState_r <= IU_COUNT;
                end
              end else begin
                adc_r <= adc_r + 1'b1;
              end
            end else begin
              adc_r <= adc_r + 1'b1;
            end
          end
          IU_COUNT: begin
            evCnt_r <= evCnt_r + 1'b1;
            if (!continuous && (evCnt_r + 1'b1 == target_r)) begin
              active_r  <= 1'b0;
              iuState_r <= IU_IDLE;
            end else begin
              iuState_r <= IU_WAIT;
            end
          end
          IU_HALT: iuState_r <= IU_HALT;
        endcase
      end
    end
  end

  // Input unit error flags: set by the fault, cleared by disable.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      frameErr_r <= 1'b0;
      cnvErr_r   <= 1'b0;
      ovfErr_r   <= 1'b0;
    end else if (clkEn) begin
      if (!iuEna_r) begin
        frameErr_r <= 1'b0;
        cnvErr_r   <= 1'b0;
        ovfErr_r   <= 1'b0;
      end else if (iuState_r != IU_HALT) begin
        if (trigHit && active_r && !continuous) begin
          frameErr_r <= 1'b1;
        end
        if (convFall && (iuState_r inside {IU_PULSE, IU_CONV, IU_STORE, IU_COUNT})) begin
          cnvErr_r <= 1'b1;
        end
        if ((iuState_r == IU_STORE) && laneOn[adc_r] && fifoFull) begin
          ovfErr_r <= 1'b1;
        end
      end
    end
  end

  // Sample FIFO storage and level; level counts both ends at once.
  always_ff @(posedge core_clk) begin
    if (clkEn && push) begin
      mem[wrPtr_r] <= pushEntry;
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      fill_r  <= '0;
    end else if (clkEn) begin
      if (push) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
      fill_r <= fill_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Engine pops one sample when it issues a host write.
  assign pop = (dmaState_r == D_XFER) && dmaEna_r && !fifoEmpty &&
               !(head.frameStart && (bytes_r != '0));

  // Transfer engine: buffer walk, host writes and status word.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dmaState_r  <= D_OFF;
      memValid    <= 1'b0;
      memReq      <= '0;
      writePtr_r  <= asd_pkg::RST_WORD;
      remain_r    <= '0;
      bytes_r     <= '0;
      term_r      <= '0;
      curSample_r <= '0;
    end else if (clkEn) begin
      unique case (dmaState_r)
        D_OFF: begin
          if (dmaEna_r) begin
            dmaState_r <= D_IDLE;
          end
        end
        D_IDLE: begin
          if (!dmaEna_r) begin
            dmaState_r <= D_OFF;
          end else if (lenStart) begin
            writePtr_r <= base_r;
            remain_r   <= regWrData[asd_pkg::CNT_W-1:0];
            bytes_r    <= '0;
            term_r     <= '0;
            dmaState_r <= D_XFER;
          end
        end
        D_XFER: begin
          if (!dmaEna_r) begin
            dmaState_r <= D_OFF;
          end else if (!fifoEmpty && head.frameStart && (bytes_r != '0)) begin
            term_r[asd_pkg::TERM_BLOCK] <= 1'b1;
            dmaState_r <= statEna_r ? D_STAT : D_IDLE;
          end else if (!fifoEmpty) begin
            curSample_r    <= head;
            memValid       <= 1'b1;
            memReq.addr    <= writePtr_r;
            memReq.data    <= {head.data, head.data};
            memReq.byteEn  <= writePtr_r[1] ? 4'hc : 4'h3;
            dmaState_r     <= D_WRITE;
          end else if (iuErr) begin
            term_r[asd_pkg::TERM_ABORT] <= 1'b1;
            dmaState_r <= statEna_r ? D_STAT : D_IDLE;
          end
        end
        D_WRITE: begin
          if (memMasterAbort || memTargetAbort) begin
            memValid   <= 1'b0;
            dmaState_r <= D_ERR;
          end else if (memAck) begin
            memValid   <= 1'b0;
            writePtr_r <= writePtr_r + 32'(asd_pkg::SAMPLE_BYTES);
            bytes_r    <= bytes_r + STEP;
            remain_r   <= (remain_r > STEP) ? remain_r - STEP : '0;
            if (remain_r <= STEP || curSample_r.blockEnd) begin
              term_r[asd_pkg::TERM_BUFEND] <= (remain_r <= STEP);
              term_r[asd_pkg::TERM_BLOCK] <= curSample_r.blockEnd;
              dmaState_r <= statEna_r ? D_STAT : (dmaEna_r ? D_IDLE : D_OFF);
            end else begin
              dmaState_r <= dmaEna_r ? D_XFER : D_OFF;
            end
          end
        end
        D_STAT: begin
          memValid      <= 1'b1;
          memReq.addr   <= stAddr_r;
          memReq.data   <= {1'b0, term_r, bytes_r};
          memReq.byteEn <= 4'hf;
          dmaState_r    <= D_STATW;
        end
        D_STATW: begin
          if (memMasterAbort || memTargetAbort) begin
            memValid   <= 1'b0;
            dmaState_r <= D_ERR;
          end else if (memAck) begin
            memValid   <= 1'b0;
            dmaState_r <= dmaEna_r ? D_IDLE : D_OFF;
          end
        end
        D_ERR: begin
          if (!dmaEna_r) begin
            dmaState_r <= D_OFF;
          end
        end
      endcase
    end
  end

  // Transfer error flag: an abort sets it, disable clears it.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      xferErr_r <= 1'b0;
    end else if (clkEn) begin
      if ((dmaState_r inside {D_WRITE, D_STATW}) &&
          (memMasterAbort || memTargetAbort)) begin
        xferErr_r <= 1'b1;
      end else if (!dmaEna_r) begin
        xferErr_r <= 1'b0;
      end
    end
  end

  // Register reads answer one cycle after the strobe.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      regRdData <= asd_pkg::RST_WORD;
    end else if (clkEn) begin
      regRdData <= asd_pkg::RST_WORD;
      if (regRd) begin
        unique case (regAddr)
          asd_pkg::OFS_STATUS: begin
            regRdData[asd_pkg::ST_TERM_LSB +: 3] <= term_r;
            regRdData[asd_pkg::ST_DMA_ERR]   <= xferErr_r;
            regRdData[asd_pkg::ST_DMA_BSY]   <=
              dmaState_r inside {D_XFER, D_WRITE, D_STAT, D_STATW};
            regRdData[asd_pkg::ST_DMA_IDLE]  <= (dmaState_r == D_IDLE);
            regRdData[asd_pkg::ST_FRAME_ERR] <= frameErr_r;
            regRdData[asd_pkg::ST_CNV_ERR]   <= cnvErr_r;
            regRdData[asd_pkg::ST_FIFO_OF]   <= ovfErr_r;
            regRdData[asd_pkg::ST_CNV_ACT]   <= active_r;
            regRdData[asd_pkg::ST_IU_IDLE]   <= (iuState_r == IU_IDLE);
          end
          asd_pkg::OFS_CTRL: begin
            regRdData[asd_pkg::CTL_IU_ENA]   <= iuEna_r;
            regRdData[asd_pkg::CTL_FRAME]    <= frameMode_r;
            regRdData[asd_pkg::CTL_DMA_ENA]  <= dmaEna_r;
            regRdData[asd_pkg::CTL_STAT_ENA] <= statEna_r;
          end
          asd_pkg::OFS_TARGET: regRdData <= 32'(target_r);
          asd_pkg::OFS_EVCNT:  regRdData <= 32'(evCnt_r);
          asd_pkg::OFS_FILL:   regRdData <= 32'({fill_r, 1'b0});
          asd_pkg::OFS_BASE:   regRdData <= base_r;
          asd_pkg::OFS_LEN:    regRdData <= 32'(len_r);
          asd_pkg::OFS_NEXT:   regRdData <= writePtr_r;
          asd_pkg::OFS_STADDR: regRdData <= stAddr_r;
          default: regRdData <= asd_pkg::RST_WORD;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> pkg/asd_pkg.sv
/*
  Constants and carriers of the sequencer back end.
  Assumes a 12-bit byte address on the register port.
*/
`default_nettype none
package asd_pkg;
  // Register byte offsets.
  localparam logic [11:0] OFS_STATUS = 12'h124;
  localparam logic [11:0] OFS_TARGET = 12'h12c;
  localparam logic [11:0] OFS_EVCNT  = 12'h130;
  localparam logic [11:0] OFS_FILL   = 12'h134;
  localparam logic [11:0] OFS_CTRL   = 12'h138;
  localparam logic [11:0] OFS_BASE   = 12'h140;
  localparam logic [11:0] OFS_LEN    = 12'h144;
  localparam logic [11:0] OFS_NEXT   = 12'h148;
  localparam logic [11:0] OFS_STADDR = 12'h14c;
  // Control register bit positions.
  localparam int CTL_IU_ENA   = 0;
  localparam int CTL_FRAME    = 2;
  localparam int CTL_START    = 3;
  localparam int CTL_DMA_ENA  = 16;
  localparam int CTL_STAT_ENA = 18;
  // Status register bit positions.
  localparam int ST_IU_IDLE   = 0;
  localparam int ST_CNV_ACT   = 2;
  localparam int ST_FIFO_OF   = 4;
  localparam int ST_CNV_ERR   = 5;
  localparam int ST_FRAME_ERR = 6;
  localparam int ST_DMA_IDLE  = 16;
  localparam int ST_DMA_BSY   = 17;
  localparam int ST_DMA_ERR   = 18;
  localparam int ST_TERM_LSB  = 20;
  // Termination reason bits inside the three-bit field.
  localparam int TERM_BUFEND = 0;
  localparam int TERM_BLOCK  = 1;
  localparam int TERM_ABORT  = 2;
  // Status word layout and counter width.
  localparam int SW_TERM_LSB = 28;
  localparam int CNT_W       = 28;
  // Sample FIFO geometry.
  localparam int FIFO_BYTES   = 65536;
  localparam int SAMPLE_BYTES = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Entry of the sample FIFO.
  typedef struct packed {
    logic        frameStart;
    logic        blockEnd;
    logic [15:0] data;
  } asd_sample_type;
  // One host memory write.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  byteEn;
  } asd_mem_req_type;
endpackage
`default_nettype wire

// >>> test/asd_seq_dma_props.sv
/* Port checker of the sequencer back end, bound to its top module.
   Assumes the clock enable is held high. */
`timescale 1ns/1ps
`default_nettype none
module asd_seq_dma_props #(
  parameter int NUM_ADC = 4,
  parameter int CH_W    = 4
) (
  // Clock and reset.
  input wire logic                     core_clk,
  input wire logic                     reset,
  // Observed ports.
  input wire logic                     regRd,
  input wire logic [31:0]              regRdData,
  input wire logic [NUM_ADC*CH_W-1:0]  chanCount,
  input wire logic [NUM_ADC-1:0]       convPulse,
  input wire logic                     memValid,
  input wire asd_pkg::asd_mem_req_type memReq,
  input wire logic                     memAck,
  input wire logic                     memMasterAbort,
  input wire logic                     memTargetAbort
);
  logic [NUM_ADC-1:0] laneOn;
  // Marks the lanes whose converter has at least one active channel.
  always_comb begin
    for (int a = 0; a < NUM_ADC; a++) laneOn[a] = chanCount[a*CH_W+:CH_W] != '0;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // A write that still waits for its answer, and one that gets it.
  sequence s_wait; memValid && !memAck && !memMasterAbort && !memTargetAbort; endsequence
  sequence s_done; memValid && (memAck || memMasterAbort || memTargetAbort); endsequence
  chk_req_held: assert property (s_wait |=> memValid && $stable(memReq))
    else $error("Write request changed before its answer.");
  chk_req_drop: assert property (s_done |=> !memValid)
    else $error("Write request held after its answer.");
  chk_lane_enable: assert property (memValid && memReq.byteEn != 4'hf |->
    memReq.byteEn == (memReq.addr[1] ? 4'hc : 4'h3)) else $error("Bad sample lane enable.");
  chk_sample_pair: assert property (memValid && memReq.byteEn != 4'hf |->
    memReq.data[31:16] == memReq.data[15:0]) else $error("Sample halves differ.");
  chk_status_form: assert property (memValid && memReq.byteEn == 4'hf |->
    !memReq.data[31] && memReq.data[30:28] != 3'h0) else $error("Bad status word form.");
  chk_pulse_lanes: assert property ((convPulse & ~laneOn) == '0)
    else $error("Pulse on an unassigned converter.");
  chk_pulse_single: assert property (convPulse != '0 |=> convPulse == '0)
    else $error("Conversion pulse longer than one cycle.");
  chk_rd_quiet: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("Read data outside its cycle.");
endmodule
bind asd_seq_dma asd_seq_dma_props #(.NUM_ADC(NUM_ADC), .CH_W(CH_W)) i_props (
  .core_clk(core_clk), .reset(reset), .regRd(regRd), .regRdData(regRdData),
  .chanCount(chanCount), .convPulse(convPulse), .memValid(memValid), .memReq(memReq),
  .memAck(memAck), .memMasterAbort(memMasterAbort), .memTargetAbort(memTargetAbort));
`default_nettype wire

// >>> test/asd_host_mem.sv
/* Host memory model answering the transfer engine's writes.
   Assumes one outstanding write; the bench sets wait and fault kind. */
`timescale 1ns/1ps
`default_nettype none
module asd_host_mem (
  // Clock and reset.
  input wire logic                     core_clk,
  input wire logic                     reset,
  // Write port.
  input wire logic                     memValid,
  input wire asd_pkg::asd_mem_req_type memReq,
  output logic                         memAck,
  output logic                         memMasterAbort,
  output logic                         memTargetAbort,
  // Wait cycles, and fault kind: 0 none, 1 master abort, 2 target abort.
  input wire logic [3:0]               delay,
  input wire logic [1:0]               fault
);
  logic [31:0] memData_r [64];
  logic [3:0]  waitCnt_r;
  logic        gap_r;
  // Answers after the set wait, then stays quiet one cycle so no answer repeats.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      {memAck, memMasterAbort, memTargetAbort, gap_r, waitCnt_r} <= '0;
    end else begin
      {memAck, memMasterAbort, memTargetAbort} <= '0;
      gap_r <= memAck | memMasterAbort | memTargetAbort;
      if (memValid && !gap_r && !(memAck | memMasterAbort | memTargetAbort)) begin
        waitCnt_r <= waitCnt_r + 4'h1;
        if (waitCnt_r >= delay) begin
          waitCnt_r <= '0;
          memAck <= fault == 2'h0;
          memMasterAbort <= fault == 2'h1;
          memTargetAbort <= fault == 2'h2;
          for (int b = 0; b < 4; b++) begin
            if (fault == 2'h0 && memReq.byteEn[b])
              memData_r[memReq.addr[7:2]][b*8+:8] <= memReq.data[b*8+:8];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/tb_asd_seq_dma.sv
/* Bench of the sequencer back end with its host memory model.
   Assumes the bound checker watches the ports. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_asd_seq_dma;
  logic        core_clk, reset, regWr, regRd, convClk, convDone, memValid;
  logic        memAck, memMasterAbort, memTargetAbort;
  logic [11:0] regAddr, pulseN;
  logic [31:0] regWrData, regRdData, sampleData, s, p;
  logic [1:0]  convPulse, fault;
  logic [3:0]  delay;
  asd_pkg::asd_mem_req_type memReq;
  int          err_count = 0;
  int          compares = 0;
  int          halfP = 40;
  localparam logic [11:0] OFS [9] = '{12'h124, 12'h12c, 12'h130, 12'h134, 12'h140,
    12'h144, 12'h148, 12'h14c, 12'h200};
  localparam logic [31:0] EXPW [3] = '{32'h1001_0001, 32'h0003_0002, 32'h0004_1003};
  asd_seq_dma #(.NUM_ADC(2)) i_dut (.core_clk(core_clk), .reset(reset), .clkEn(1'b1),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .convClk(convClk), .frameTrig(1'b0), .chanCount(8'h12),
    .convDone(convDone), .sampleData(sampleData), .convPulse(convPulse),
    .memValid(memValid), .memReq(memReq), .memAck(memAck),
    .memMasterAbort(memMasterAbort), .memTargetAbort(memTargetAbort));
  asd_host_mem i_mem (.core_clk(core_clk), .reset(reset), .memValid(memValid),
    .memReq(memReq), .memAck(memAck), .memMasterAbort(memMasterAbort),
    .memTargetAbort(memTargetAbort), .delay(delay), .fault(fault));
  // Bus clock and a conversion clock with a settable half period.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    convClk = 1'b0;
    forever begin
      repeat (halfP) @(posedge core_clk);
      convClk <= ~convClk;
    end
  end
  // Converters answer each pulse; results carry lane and pulse number.
  always @(posedge core_clk) begin
    convDone <= |convPulse;
    pulseN <= reset ? 12'h0 : pulseN + 12'(|convPulse);
  end
  assign sampleData = {4'h1, pulseN, 4'h0, pulseN};
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d.", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
    @(posedge core_clk);
  endtask
  // Reads a register and compares the masked value.
  task automatic ck(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, p);
    `CHK($sformatf("register %h", a), e, p & m)
  endtask
  // Polls one status bit for a bounded time.
  task automatic ws(input int b, input logic v);
    for (int i = 0; i < 500; i++) begin
      rd(12'h124, s);
      if (s[b] === v) return;
    end
    `CHK($sformatf("status bit %0d", b), v, s[b])
    report_and_stop();
  endtask
  // Main sequence: two terminations, a refilled buffer, two kinds of fault.
  initial begin
    {regWr, regRd, regAddr, regWrData} = '0;
    {delay, fault} = 6'h18;
    reset = 1'b1;
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    foreach (OFS[i]) ck(OFS[i], '1, 32'h0);
    wr(12'h14c, 32'h80);
    wr(12'h12c, 32'h2);
    ck(12'h12c, '1, 32'h2);
    wr(12'h138, 32'h5_0001);
    ws(asd_pkg::ST_DMA_IDLE, 1'b1);
    ws(asd_pkg::ST_IU_IDLE, 1'b1);
    wr(12'h144, 32'h20);
    wr(12'h140, 32'h40);
    wr(12'h138, 32'h5_0009);
    ck(12'h124, 32'h4, 32'h4);
    ws(asd_pkg::ST_DMA_BSY, 1'b1);
    ws(asd_pkg::ST_CNV_ACT, 1'b0);
    ws(asd_pkg::ST_TERM_LSB + 1, 1'b1);
    ws(asd_pkg::ST_DMA_BSY, 1'b0);
    ck(12'h124, 32'h70_0000, 32'h20_0000);
    ck(12'h130, '1, 32'h2);
    ck(12'h148, '1, 32'hc);
    for (int j = 0; j < 3; j++) `CHK("sample", EXPW[j], i_mem.memData_r[j])
    `CHK("status word", 32'h2000_000c, i_mem.memData_r[32])
    wr(12'h144, 32'h6);
    ck(12'h124, 32'h70_0000, 32'h0);
    wr(12'h138, 32'h5_0009);
    ws(asd_pkg::ST_CNV_ACT, 1'b0);
    ws(asd_pkg::ST_TERM_LSB, 1'b1);
    ws(asd_pkg::ST_DMA_BSY, 1'b0);
    `CHK("status word", 32'h1000_0006, i_mem.memData_r[32])
    ck(12'h134, '1, 32'h6);
    wr(12'h144, 32'h20);
    ws(asd_pkg::ST_TERM_LSB + 1, 1'b1);
    ck(12'h134, '1, 32'h0);
    ws(asd_pkg::ST_DMA_IDLE, 1'b1);
    wr(12'h12c, 32'h0);
    wr(12'h144, 32'h20);
    halfP = 2;
    wr(12'h138, 32'h5_0009);
    ws(asd_pkg::ST_CNV_ERR, 1'b1);
    ws(asd_pkg::ST_TERM_LSB + 2, 1'b1);
    halfP = 40;
    wr(12'h138, 32'h5_0000);
    ck(12'h124, 32'h75, 32'h0);
    ws(asd_pkg::ST_DMA_IDLE, 1'b1);
    fault <= 2'h2;
    wr(12'h12c, 32'h1);
    wr(12'h144, 32'h20);
    wr(12'h138, 32'h5_0001);
    ws(asd_pkg::ST_IU_IDLE, 1'b1);
    wr(12'h138, 32'h5_0009);
    ws(asd_pkg::ST_DMA_ERR, 1'b1);
    ck(12'h124, 32'h2_0000, 32'h0);
    wr(12'h138, 32'h1);
    ck(12'h124, 32'h7_0000, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
